// ==== include/byte_memory_dma_pkg.sv ====
// How it works
// - Byte space: 256 pages of 16K bytes
// - Bytes travel on data lines 15..8
// - Page on lines 23..16, offset on 13..0
// - Wait field and mode stretch accesses
// - One core cycle stolen per word moved
// - Format picks word size and byte count
// - 8-bit formats zero the unused half
// - Internal start and direction set transfer
// - Offset and page registers give first byte
// - Word count counts whole words left
// - Nonzero count write starts, runs to zero
// - Addressing carries across page boundaries
// - Count drops per word; zero interrupts
// - On-chip side only; no external overlays
// - Complete word moves in one cycle
// - Core external accesses beat byte accesses
// - Context bit holds and restarts core
// - Overlay fields pick blocks
// - Byte select on at reset
// - Byte boot loads zeros, count 32, hold set
package byte_memory_dma_pkg;

	// Register indices; byte address is 4x
	localparam logic [13:0] IDX_SYSTEM_CONTROL = 14'h3FFF;
	localparam logic [13:0] IDX_WAIT           = 14'h3FFE;
	localparam logic [13:0] IDX_CTRL           = 14'h3FE3;
	localparam logic [13:0] IDX_EXT_OFFSET     = 14'h3FE2;
	localparam logic [13:0] IDX_INT_ADDR       = 14'h3FE1;
	localparam logic [13:0] IDX_WORD_COUNT     = 14'h3FE4;
	localparam logic [13:0] IDX_OVERLAY        = 14'h3FE5;

	// Field positions
	localparam int CTRL_DIR_BIT       = 2;
	localparam int CTRL_CTX_BIT       = 3;
	localparam int CTRL_PAGE_LSB      = 8;
	localparam int WAIT_MODE_BIT      = 15;
	localparam int SYS_BMS_DIS_BIT    = 3;
	localparam int SYS_CMS_FOLLOW_BIT = 4;
	localparam int OVL_DM_LSB         = 4;

	// Transfer formats
	localparam logic [1:0] FMT_PM24   = 2'h0;
	localparam logic [1:0] FMT_DM16   = 2'h1;
	localparam logic [1:0] FMT_DM8_HI = 2'h2;
	localparam logic [1:0] FMT_DM8_LO = 2'h3;

	// Reset and boot values, counts
	localparam logic [13:0] BOOT_WORD_COUNT = 14'h0020;
	localparam logic [3:0]  OVL_EXT1        = 4'h1;
	localparam logic [3:0]  OVL_EXT2        = 4'h2;
	localparam logic [3:0]  OVL_RESET       = 4'h0;
	localparam logic [4:0]  WAIT_MAX        = 5'h0F;
	localparam logic [4:0]  READ_SYNC_EXTRA = 5'h02;
	localparam logic [1:0]  BOOT_PHASE_LOAD = 2'h2;
	localparam logic [1:0]  BOOT_PHASE_END  = 2'h3;

	// AXI responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [6:0] {
		ST_IDLE       = 7'h01,
		ST_FETCH      = 7'h02,
		ST_FETCH_WAIT = 7'h04,
		ST_ARB        = 7'h08,
		ST_STROBE     = 7'h10,
		ST_STORE      = 7'h20,
		ST_NEXT       = 7'h40
	} dma_state_t;

endpackage : byte_memory_dma_pkg

// ==== design/sync_stages.sv ====
`timescale 1ns/10ps
`default_nettype none
module sync_stages #(
	parameter int WIDTH = 1
) (
	input  wire logic             aclk,     // Clock
	input  wire logic             aresetn,  // Reset
	input  wire logic [WIDTH-1:0] async_in, // Pin
	output logic      [WIDTH-1:0] sync_out  // Synced
);
	typedef struct packed {
		logic [WIDTH-1:0] first;
		logic [WIDTH-1:0] second;
	} sync_state_t;

	sync_state_t st;
	sync_state_t next_st;

	// Two stages
	always_comb
	begin
		next_st.first  = async_in;
		next_st.second = st.first;
	end

	// State register
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			st <= '0;
		else
			st <= next_st;
	end

	assign sync_out = st.second;
endmodule : sync_stages
`default_nettype wire

// ==== design/wait_timer.sv ====
`timescale 1ns/10ps
`default_nettype none
module wait_timer #(
	parameter int WIDTH = 5
) (
	input  wire logic             aclk,    // Clock
	input  wire logic             aresetn, // Reset
	input  wire logic             load,    // Load pulse
	input  wire logic [WIDTH-1:0] value,   // Cycles to wait
	output logic                  expired  // Count is zero
);
	typedef struct packed {
		logic [WIDTH-1:0] cnt;
	} timer_state_t;

	timer_state_t st;
	timer_state_t next_st;

	// Load, else count down
	always_comb
	begin
		next_st = st;
		if (load)
			next_st.cnt = value;
		else if (st.cnt != '0)
			next_st.cnt = st.cnt - 1'b1;
	end

	// State register
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			st <= '0;
		else
			st <= next_st;
	end

	assign expired = (st.cnt == '0);
endmodule : wait_timer
`default_nettype wire

// ==== design/byte_memory_dma.sv ====
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module byte_memory_dma (
	input  wire logic        aclk,                // Clock
	input  wire logic        aresetn,             // Reset
	input  wire logic [15:0] s_axi_awaddr,        // AW addr
	input  wire logic        s_axi_awvalid,       // AW valid
	output logic             s_axi_awready,       // AW ready
	input  wire logic [31:0] s_axi_wdata,         // W data
	input  wire logic [3:0]  s_axi_wstrb,         // W strobes
	input  wire logic        s_axi_wvalid,        // W valid
	output logic             s_axi_wready,        // W ready
	output logic [1:0]       s_axi_bresp,         // B resp
	output logic             s_axi_bvalid,        // B valid
	input  wire logic        s_axi_bready,        // B ready
	input  wire logic [15:0] s_axi_araddr,        // AR addr
	input  wire logic        s_axi_arvalid,       // AR valid
	output logic             s_axi_arready,       // AR ready
	output logic [31:0]      s_axi_rdata,         // R data
	output logic [1:0]       s_axi_rresp,         // R resp
	output logic             s_axi_rvalid,        // R valid
	input  wire logic        s_axi_rready,        // R ready
	output logic [13:0]      ext_addr,            // Address lines 13..0
	output logic [23:0]      ext_data_out,        // Data lines 23..0 out
	output logic             ext_page_oe_n,       // Page lines enable
	output logic             ext_byte_oe_n,       // Byte lines enable
	input  wire logic [7:0]  ext_byte_in,         // Lines 15..8 in
	output logic             ext_rd_n,            // Read strobe
	output logic             ext_wr_n,            // Write strobe
	output logic             byte_space_select_n, // Byte memory select
	output logic             combined_select_n,   // Composite select
	input  wire logic        core_ext_req,        // Core bus use
	output logic             mem_req,             // On-chip access
	output logic             mem_write,           // On-chip write
	output logic             mem_space_pm,        // Program memory side
	output logic [3:0]       mem_overlay,         // Overlay block
	output logic [13:0]      mem_addr,            // On-chip address
	output logic [23:0]      mem_wdata,           // On-chip write data
	input  wire logic [23:0] mem_rdata,           // On-chip read data
	output logic             core_hold,           // Core hold
	output logic             core_restart,        // Core restart
	output logic             done_irq,            // Completion pulse
	input  wire logic        boot_from_byte_mem   // Boot strap pin
);
	typedef struct packed {
		byte_memory_dma_pkg::dma_state_t fsm;
		logic        aw_held;
		logic [15:0] aw_addr;
		logic        w_held;
		logic [31:0] w_data;
		logic [3:0]  w_strb;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		logic [1:0]  format;
		logic        dir;
		logic        ctx_reset;
		logic [7:0]  page;
		logic [3:0]  pm_ovl;
		logic [3:0]  dm_ovl;
		logic [13:0] int_addr;
		logic [13:0] ext_off;
		logic [13:0] count;
		logic [3:0]  byte_wait;
		logic        wait_mode;
		logic        bms_disable;
		logic        cms_follow;
		logic        strobe;
		logic [23:0] word;
		logic [1:0]  bytes_left;
		logic        done_pulse;
		logic        restart_pulse;
		logic        mem_req;
		logic        mem_we;
		logic [23:0] mem_wdata;
		logic [1:0]  boot_phase;
	} dma_regs_t;

	dma_regs_t   st;
	dma_regs_t   next_st;
	logic [7:0]  byte_sync;
	logic        boot_sync;
	logic        timer_load;
	logic [4:0]  timer_value;
	logic        timer_expired;
	logic [4:0]  eff_wait;
	logic [15:0] ctrl_view;
	logic [15:0] wval;
	logic        busy;

	// Byte lane merge
	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
		merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
	endfunction : merge16

	// Filter external overlays
	function automatic logic [3:0] safe_ovl(input logic [3:0] v);
		safe_ovl = (v == byte_memory_dma_pkg::OVL_EXT1 || v == byte_memory_dma_pkg::OVL_EXT2) ?
			byte_memory_dma_pkg::OVL_RESET : v;
	endfunction : safe_ovl

	// Byte accesses needed per word
	function automatic logic [1:0] bytes_for(input logic [1:0] f);
		case (f)
			byte_memory_dma_pkg::FMT_PM24: bytes_for = 2'h3;
			byte_memory_dma_pkg::FMT_DM16: bytes_for = 2'h2;
			default:                       bytes_for = 2'h1;
		endcase
	endfunction : bytes_for

	// Pin synchronisers
	sync_stages #(.WIDTH(8)) u_byte_sync (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.async_in (ext_byte_in),
		.sync_out (byte_sync)
	);

	sync_stages #(.WIDTH(1)) u_boot_sync (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.async_in (boot_from_byte_mem),
		.sync_out (boot_sync)
	);

	// Strobe length counter
	wait_timer #(.WIDTH(5)) u_wait (
		.aclk    (aclk),
		.aresetn (aresetn),
		.load    (timer_load),
		.value   (timer_value),
		.expired (timer_expired)
	);

	// Derived views
	always_comb
	begin
		busy = (st.count != 14'h0000);
		ctrl_view = {st.page, 3'h0, busy, st.ctx_reset, st.dir, st.format};
		eff_wait = st.wait_mode ? {st.byte_wait, 1'b1} : {1'b0, st.byte_wait};
		if (eff_wait > byte_memory_dma_pkg::WAIT_MAX)
			eff_wait = byte_memory_dma_pkg::WAIT_MAX;
	end

	// Next state
	always_comb
	begin
		next_st = st;
		next_st.done_pulse = 1'b0;
		next_st.restart_pulse = 1'b0;
		next_st.mem_req = 1'b0;
		timer_load = 1'b0;
		timer_value = 5'h00;
		wval = 16'h0000;

		// Boot defaults
		if (st.boot_phase != byte_memory_dma_pkg::BOOT_PHASE_END)
			next_st.boot_phase = st.boot_phase + 2'h1;
		if (st.boot_phase == byte_memory_dma_pkg::BOOT_PHASE_LOAD && boot_sync)
		begin
			next_st.dir = 1'b0;
			next_st.page = 8'h00;
			next_st.int_addr = 14'h0000;
			next_st.ext_off = 14'h0000;
			next_st.format = byte_memory_dma_pkg::FMT_PM24;
			next_st.count = byte_memory_dma_pkg::BOOT_WORD_COUNT;
			next_st.ctx_reset = 1'b1;
		end

		// Transfer engine
		case (st.fsm)
			byte_memory_dma_pkg::ST_IDLE:
			begin
				if (busy)
				begin
					next_st.bytes_left = bytes_for(st.format);
					next_st.fsm = st.dir ? byte_memory_dma_pkg::ST_FETCH : byte_memory_dma_pkg::ST_ARB;
				end
			end
			byte_memory_dma_pkg::ST_FETCH:
			begin
				next_st.mem_req = 1'b1;
				next_st.mem_we = 1'b0;
				next_st.fsm = byte_memory_dma_pkg::ST_FETCH_WAIT;
			end
			byte_memory_dma_pkg::ST_FETCH_WAIT:
			begin
				// First byte to the top
				case (st.format)
					byte_memory_dma_pkg::FMT_PM24:   next_st.word = mem_rdata;
					byte_memory_dma_pkg::FMT_DM16:   next_st.word = {mem_rdata[15:0], 8'h00};
					byte_memory_dma_pkg::FMT_DM8_HI: next_st.word = {mem_rdata[15:8], 16'h0000};
					default:                         next_st.word = {mem_rdata[7:0], 16'h0000};
				endcase
				next_st.fsm = byte_memory_dma_pkg::ST_ARB;
			end
			byte_memory_dma_pkg::ST_ARB:
			begin
				if (!core_ext_req)
				begin
					next_st.strobe = 1'b1;
					timer_load = 1'b1;
					timer_value = st.dir ? eff_wait : 5'(eff_wait + byte_memory_dma_pkg::READ_SYNC_EXTRA);
					next_st.fsm = byte_memory_dma_pkg::ST_STROBE;
				end
			end
			byte_memory_dma_pkg::ST_STROBE:
			begin
				if (timer_expired)
				begin
					next_st.strobe = 1'b0;
					{next_st.page, next_st.ext_off} = 22'({st.page, st.ext_off} + 22'h000001);
					next_st.word = st.dir ? {st.word[15:0], 8'h00} : {st.word[15:0], byte_sync};
					next_st.bytes_left = st.bytes_left - 2'h1;
					if (st.bytes_left != 2'h1)
						next_st.fsm = byte_memory_dma_pkg::ST_ARB;
					else if (st.dir)
						next_st.fsm = byte_memory_dma_pkg::ST_NEXT;
					else
						next_st.fsm = byte_memory_dma_pkg::ST_STORE;
				end
			end
			byte_memory_dma_pkg::ST_STORE:
			begin
				next_st.mem_req = 1'b1;
				next_st.mem_we = 1'b1;
				case (st.format)
					byte_memory_dma_pkg::FMT_PM24:   next_st.mem_wdata = st.word;
					byte_memory_dma_pkg::FMT_DM16:   next_st.mem_wdata = {8'h00, st.word[15:0]};
					byte_memory_dma_pkg::FMT_DM8_HI: next_st.mem_wdata = {8'h00, st.word[7:0], 8'h00};
					default:                         next_st.mem_wdata = {16'h0000, st.word[7:0]};
				endcase
				next_st.fsm = byte_memory_dma_pkg::ST_NEXT;
			end
			byte_memory_dma_pkg::ST_NEXT:
			begin
				if (busy)
					next_st.count = st.count - 14'h0001;
				next_st.int_addr = st.int_addr + 14'h0001;
				if (st.count == 14'h0001)
				begin
					next_st.done_pulse = 1'b1;
					next_st.restart_pulse = st.ctx_reset;
				end
				next_st.fsm = byte_memory_dma_pkg::ST_IDLE;
			end
			default:
			begin
				next_st.fsm = byte_memory_dma_pkg::ST_IDLE;
				next_st.strobe = 1'b0;
			end
		endcase

		// AW and W in either order
		if (s_axi_awvalid && s_axi_awready)
		begin
			next_st.aw_held = 1'b1;
			next_st.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			next_st.w_held = 1'b1;
			next_st.w_data = s_axi_wdata;
			next_st.w_strb = s_axi_wstrb;
		end
		if (st.bvalid && s_axi_bready)
			next_st.bvalid = 1'b0;

		// Register write, wins over engine
		if (st.aw_held && st.w_held && !st.bvalid)
		begin
			next_st.aw_held = 1'b0;
			next_st.w_held = 1'b0;
			next_st.bvalid = 1'b1;
			next_st.bresp = byte_memory_dma_pkg::RESP_OKAY;
			case (st.aw_addr[15:2])
				byte_memory_dma_pkg::IDX_CTRL:
				begin
					wval = merge16(ctrl_view, st.w_data, st.w_strb);
					next_st.format = wval[1:0];
					next_st.dir = wval[byte_memory_dma_pkg::CTRL_DIR_BIT];
					next_st.ctx_reset = wval[byte_memory_dma_pkg::CTRL_CTX_BIT];
					next_st.page = wval[byte_memory_dma_pkg::CTRL_PAGE_LSB +: 8];
				end
				byte_memory_dma_pkg::IDX_EXT_OFFSET:
				begin
					wval = merge16({2'h0, st.ext_off}, st.w_data, st.w_strb);
					next_st.ext_off = wval[13:0];
				end
				byte_memory_dma_pkg::IDX_INT_ADDR:
				begin
					wval = merge16({2'h0, st.int_addr}, st.w_data, st.w_strb);
					next_st.int_addr = wval[13:0];
				end
				byte_memory_dma_pkg::IDX_WORD_COUNT:
				begin
					wval = merge16({2'h0, st.count}, st.w_data, st.w_strb);
					next_st.count = wval[13:0];
				end
				byte_memory_dma_pkg::IDX_OVERLAY:
				begin
					wval = merge16({8'h00, st.dm_ovl, st.pm_ovl}, st.w_data, st.w_strb);
					next_st.pm_ovl = safe_ovl(wval[3:0]);
					next_st.dm_ovl = safe_ovl(wval[byte_memory_dma_pkg::OVL_DM_LSB +: 4]);
				end
				byte_memory_dma_pkg::IDX_WAIT:
				begin
					wval = merge16({st.wait_mode, 11'h000, st.byte_wait}, st.w_data, st.w_strb);
					next_st.byte_wait = wval[3:0];
					next_st.wait_mode = wval[byte_memory_dma_pkg::WAIT_MODE_BIT];
				end
				byte_memory_dma_pkg::IDX_SYSTEM_CONTROL:
				begin
					wval = merge16({11'h000, st.cms_follow, st.bms_disable, 3'h0}, st.w_data, st.w_strb);
					next_st.bms_disable = wval[byte_memory_dma_pkg::SYS_BMS_DIS_BIT];
					next_st.cms_follow = wval[byte_memory_dma_pkg::SYS_CMS_FOLLOW_BIT];
				end
				default:
					next_st.bresp = byte_memory_dma_pkg::RESP_SLVERR;
			endcase
		end

		// Register read
		if (st.rvalid && s_axi_rready)
			next_st.rvalid = 1'b0;
		if (s_axi_arvalid && s_axi_arready)
		begin
			next_st.rvalid = 1'b1;
			next_st.rresp = byte_memory_dma_pkg::RESP_OKAY;
			case (s_axi_araddr[15:2])
				byte_memory_dma_pkg::IDX_CTRL:           next_st.rdata = {16'h0000, ctrl_view};
				byte_memory_dma_pkg::IDX_EXT_OFFSET:     next_st.rdata = {18'h00000, st.ext_off};
				byte_memory_dma_pkg::IDX_INT_ADDR:       next_st.rdata = {18'h00000, st.int_addr};
				byte_memory_dma_pkg::IDX_WORD_COUNT:     next_st.rdata = {18'h00000, st.count};
				byte_memory_dma_pkg::IDX_OVERLAY:        next_st.rdata = {24'h000000, st.dm_ovl, st.pm_ovl};
				byte_memory_dma_pkg::IDX_WAIT:           next_st.rdata = {16'h0000, st.wait_mode, 11'h000, st.byte_wait};
				byte_memory_dma_pkg::IDX_SYSTEM_CONTROL: next_st.rdata = {27'h0000000, st.cms_follow, st.bms_disable, 3'h0};
				default:
				begin
					next_st.rdata = 32'h00000000;
					next_st.rresp = byte_memory_dma_pkg::RESP_SLVERR;
				end
			endcase
		end
	end

	// State register
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			st <= '0;
			st.fsm <= byte_memory_dma_pkg::ST_IDLE;
		end
		else
			st <= next_st;
	end

	// Bus handshakes
	assign s_axi_awready = !st.aw_held && !st.bvalid;
	assign s_axi_wready  = !st.w_held && !st.bvalid;
	assign s_axi_bvalid  = st.bvalid;
	assign s_axi_bresp   = st.bresp;
	assign s_axi_arready = !st.rvalid;
	assign s_axi_rvalid  = st.rvalid;
	assign s_axi_rdata   = st.rdata;
	assign s_axi_rresp   = st.rresp;

	// External byte bus
	assign ext_addr            = st.ext_off;
	assign ext_data_out        = {st.page, st.word[23:16], 8'h00};
	assign ext_page_oe_n       = !st.strobe;
	assign ext_byte_oe_n       = !(st.strobe && st.dir);
	assign ext_rd_n            = !(st.strobe && !st.dir);
	assign ext_wr_n            = !(st.strobe && st.dir);
	assign byte_space_select_n = !(st.strobe && !st.bms_disable);
	assign combined_select_n   = !(st.strobe && st.cms_follow);

	// On-chip memory side
	assign mem_req      = st.mem_req;
	assign mem_write    = st.mem_we;
	assign mem_space_pm = (st.format == byte_memory_dma_pkg::FMT_PM24);
	assign mem_overlay  = mem_space_pm ? st.pm_ovl : st.dm_ovl;
	assign mem_addr     = st.int_addr;
	assign mem_wdata    = st.mem_wdata;

	// Core control
	assign core_hold    = busy && st.ctx_reset;
	assign core_restart = st.restart_pulse;
	assign done_irq     = st.done_pulse;
endmodule : byte_memory_dma
`default_nettype wire

// ==== verif/byte_memory_dma_assertions.sv ====
`timescale 1ns/10ps
`default_nettype none
module byte_memory_dma_checker (
	input wire logic        aclk,                // Clock
	input wire logic        aresetn,             // Reset
	input wire logic [13:0] ext_addr,            // Byte offset
	input wire logic [23:0] ext_data_out,        // Page and byte
	input wire logic        ext_page_oe_n,       // Page lines enable
	input wire logic        ext_byte_oe_n,       // Byte lines enable
	input wire logic        ext_rd_n,            // Read strobe
	input wire logic        ext_wr_n,            // Write strobe
	input wire logic        byte_space_select_n, // Byte select
	input wire logic        core_ext_req,        // Core bus use
	input wire logic        mem_req,             // On-chip access
	input wire logic [3:0]  mem_overlay,         // Overlay block
	input wire logic        core_restart,        // Core restart
	input wire logic        done_irq             // Completion pulse
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	property p_irq_pulse; done_irq |=> !done_irq; endproperty
	a_irq_pulse: assert property (p_irq_pulse) else $error("irq too long");
	property p_mem_pulse; mem_req |=> !mem_req; endproperty
	a_mem_pulse: assert property (p_mem_pulse) else $error("req too long");
	property p_restart; core_restart |=> !core_restart; endproperty
	a_restart: assert property (p_restart) else $error("restart too long");
	property p_no_ovl; mem_req |-> mem_overlay != 4'h1 && mem_overlay != 4'h2; endproperty
	a_no_ovl: assert property (p_no_ovl) else $error("bad overlay");
	property p_page_oe; (!ext_rd_n || !ext_wr_n) |-> !ext_page_oe_n; endproperty
	a_page_oe: assert property (p_page_oe) else $error("page not driven");
	property p_byte_oe; (!ext_rd_n || !ext_wr_n) |-> ext_byte_oe_n == ext_wr_n; endproperty
	a_byte_oe: assert property (p_byte_oe) else $error("byte oe wrong");
	property p_hold; !ext_rd_n && $past(!ext_rd_n) |-> $stable(ext_addr) && $stable(ext_data_out[23:16]); endproperty
	a_hold: assert property (p_hold) else $error("addr moved");
	property p_step; $rose(ext_rd_n) || $rose(ext_wr_n) |-> ext_addr == $past(ext_addr) + 14'h1; endproperty
	a_step: assert property (p_step) else $error("no step");
	property p_carry;
		($rose(ext_rd_n) || $rose(ext_wr_n)) && $past(ext_addr) == 14'h3FFF
			|-> ext_data_out[23:16] == $past(ext_data_out[23:16]) + 8'h01;
	endproperty
	a_carry: assert property (p_carry) else $error("no carry");
	property p_sel; !byte_space_select_n |-> !ext_rd_n || !ext_wr_n; endproperty
	a_sel: assert property (p_sel) else $error("stray select");
	property p_yield; $fell(ext_rd_n) || $fell(ext_wr_n) |-> !$past(core_ext_req); endproperty
	a_yield: assert property (p_yield) else $error("core overridden");
endmodule : byte_memory_dma_checker
bind byte_memory_dma byte_memory_dma_checker u_chk (.*);
`default_nettype wire

// ==== verif/byte_space_memory.sv ====
`timescale 1ns/10ps
`default_nettype none
module byte_space_memory (
	input wire logic        aclk,                // Clock
	input wire logic [13:0] ext_addr,            // Byte offset
	input wire logic [23:0] ext_data_out,        // Page and byte
	input wire logic        ext_rd_n,            // Read strobe
	input wire logic        ext_wr_n,            // Write strobe
	input wire logic        ext_byte_oe_n,       // Byte lines enable
	input wire logic        byte_space_select_n, // Byte select
	input wire logic        combined_select_n,   // Composite select
	input wire logic [3:0]  lag,                 // Read access delay
	output logic     [7:0]  ext_byte_in          // Byte lines
);
	logic [7:0] mem [0:1023];
	logic [7:0] last = 8'h00;
	logic [4:0] cyc = 5'h00;
	logic       sel;
	logic [9:0] idx;
	// Cell from page and offset
	assign idx = {ext_data_out[17:16], ext_addr[7:0]};
	assign sel = !byte_space_select_n || !combined_select_n;
	// Data after lag, else inverse
	assign ext_byte_in = (sel && !ext_rd_n && cyc >= {1'b0, lag}) ? mem[idx] : ~last;
	// Known pattern
	initial
	begin
		for (int i = 0; i < 1024; i++)
			mem[i] = {i[9:8], i[5:0]} ^ 8'hA5;
	end
	// Strobe age and writes
	always @(posedge aclk)
	begin
		cyc <= ext_rd_n ? 5'h00 : cyc + 5'h01;
		if (sel && !ext_rd_n && cyc >= {1'b0, lag})
			last <= mem[idx];
		if (sel && !ext_wr_n && !ext_byte_oe_n)
			mem[idx] <= ext_data_out[15:8];
	end
endmodule : byte_space_memory
`default_nettype wire

// ==== verif/byte_memory_dma_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module byte_memory_dma_tb;
	localparam logic [15:0] A_CTRL = {byte_memory_dma_pkg::IDX_CTRL, 2'h0},
		A_OFF = {byte_memory_dma_pkg::IDX_EXT_OFFSET, 2'h0}, A_IAD = {byte_memory_dma_pkg::IDX_INT_ADDR, 2'h0},
		A_CNT = {byte_memory_dma_pkg::IDX_WORD_COUNT, 2'h0}, A_OVL = {byte_memory_dma_pkg::IDX_OVERLAY, 2'h0},
		A_WT = {byte_memory_dma_pkg::IDX_WAIT, 2'h0}, A_SYS = {byte_memory_dma_pkg::IDX_SYSTEM_CONTROL, 2'h0};
	logic        aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, core_ext_req = 1'b0, boot_from_byte_mem = 1'b0;
	logic [15:0] s_axi_awaddr = 16'h0000, s_axi_araddr = 16'h0000;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
	logic [3:0]  s_axi_wstrb = 4'hF, lag = 4'h0, mem_overlay, ovl;
	logic [23:0] mem_rdata = 24'h0, ext_data_out, mem_wdata, wq[$];
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, ext_page_oe_n;
	logic        ext_byte_oe_n, ext_rd_n, ext_wr_n, byte_space_select_n, combined_select_n, pm;
	logic        mem_req, mem_write, mem_space_pm, core_hold, core_restart, done_irq;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rr, br;
	logic [13:0] ext_addr, mem_addr, raddr;
	logic [7:0]  ext_byte_in;
	int          errors = 0, checked = 0, irqs, rsts, holds, rdcyc, bsel, csel;

	byte_memory_dma dut (.*);
	byte_space_memory mdl (.*);

	always #50 aclk = ~aclk;
	// Sample settled outputs
	always @(negedge aclk)
	begin
		if (mem_req)
			wq.push_back(mem_wdata);
		if (mem_req)
			ovl = mem_overlay;
		pm = mem_req ? mem_space_pm : pm;
		raddr = (mem_req && !mem_write) ? mem_addr : raddr;
		irqs += done_irq;
		rsts += core_restart;
		holds += core_hold;
		rdcyc += !ext_rd_n;
		bsel += !byte_space_select_n;
		csel += !combined_select_n;
	end
	always @(posedge aclk)
		mem_rdata <= {8'hC3, 2'h0, mem_addr};

	function automatic logic [7:0] pat(input logic [7:0] p, input logic [13:0] o);
		return {p[1:0], o[5:0]} ^ 8'hA5;
	endfunction : pat
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e)
		begin
			errors++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic axw(input logic [15:0] a, input logic [31:0] d);
		logic ta, tw, tb;
		{ta, tw, tb} = 3'h0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		while (!(ta && tw && tb))
		begin
			@(negedge aclk);
			ta = ta || (s_axi_awvalid && s_axi_awready);
			tw = tw || (s_axi_wvalid && s_axi_wready);
			tb = s_axi_bvalid;
			br = s_axi_bresp;
			@(posedge aclk);
			{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {!ta, !tw, !tb};
		end
	endtask : axw
	task automatic axr(input logic [15:0] a);
		logic ta, tr;
		{ta, tr} = 2'h0;
		@(posedge aclk);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		while (!tr)
		begin
			@(negedge aclk);
			ta = ta || (s_axi_arvalid && s_axi_arready);
			tr = s_axi_rvalid;
			{rd, rr} = {s_axi_rdata, s_axi_rresp};
			@(posedge aclk);
			{s_axi_arvalid, s_axi_rready} <= {!ta, !tr};
		end
	endtask : axr
	task automatic rst(input logic strap);
		aresetn <= 1'b0;
		boot_from_byte_mem <= strap;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
	endtask : rst
	task automatic wdone();
		for (int k = 0; k < 4000 && irqs < 1; k++)
			@(posedge aclk);
		chk("done pulses", 1, irqs);
	endtask : wdone
	task automatic go(input logic [1:0] f, input logic d, input logic [7:0] p, input logic [13:0] o, i, n);
		{irqs, rsts, holds, rdcyc, bsel, csel} = '0;
		wq.delete();
		axw(A_OFF, {18'h0, o});
		axw(A_IAD, {18'h0, i});
		axw(A_CTRL, {16'h0, p, 5'h0, d, f});
		axw(A_CNT, {18'h0, n});
		wdone();
		axr(A_CNT);
		chk("count left", 0, rd);
	endtask : go
	task automatic t_regs();
		axr(A_CTRL);
		chk("ctrl", 0, rd);
		axr(16'h0000);
		chk("read resp", 2, rr);
		axw(16'h0000, 32'hFFFF);
		chk("write resp", 2, br);
		axw(A_OVL, 32'h0041);
		axr(A_OVL);
		chk("overlay", 32'h0040, rd);
		$display("regs done");
	endtask : t_regs
	task automatic t_cross();
		go(2'h0, 1'h0, 8'h05, 14'h3FFF, 14'h0100, 14'h0002);
		chk("word 0", {pat(8'h05, 14'h3FFF), pat(8'h06, 14'h0), pat(8'h06, 14'h1)}, wq[0]);
		chk("word 1", {pat(8'h06, 14'h2), pat(8'h06, 14'h3), pat(8'h06, 14'h4)}, wq[1]);
		chk("pm side", 1, pm);
		chk("no hold", 0, holds);
		$display("cross done");
	endtask : t_cross
	task automatic t_formats();
		logic [7:0] b0, b1;
		b0 = pat(8'h01, 14'h0020);
		b1 = pat(8'h01, 14'h0021);
		for (int f = 1; f < 4; f++)
		begin
			go(f[1:0], 1'h0, 8'h01, 14'h0020, 14'h0200, 14'h0001);
			chk("word", f == 1 ? {8'h0, b0, b1} : f == 2 ? {8'h0, b0, 8'h0} : {16'h0, b0}, wq[0]);
			chk("dm overlay", 4, ovl);
			chk("dm side", 0, pm);
		end
		go(2'h1, 1'h1, 8'h02, 14'h0010, 14'h0123, 14'h0001);
		chk("fetch addr", 14'h0123, raddr);
		chk("byte 0", 8'h01, mdl.mem[10'h210]);
		chk("byte 1", 8'h23, mdl.mem[10'h211]);
		$display("formats done");
	endtask : t_formats
	task automatic t_waits();
		int w, e;
		for (int k = 0; k < 4; k++)
		begin
			w = k < 2 ? 3 : 15;
			e = 3 + (k[0] ? (2 * w + 1 > 15 ? 15 : 2 * w + 1) : w);
			lag <= w[3:0];
			axw(A_WT, {16'h0, k[0], 11'h0, w[3:0]});
			go(2'h3, 1'h0, 8'h01, 14'h0020, 14'h0300, 14'h0001);
			chk("strobes", e, rdcyc);
			chk("selects", e, bsel);
			chk("slow byte", {16'h0, pat(8'h01, 14'h0020)}, wq[0]);
		end
		lag <= 4'h0;
		axw(A_WT, 32'h0);
		core_ext_req <= 1'b1;
		fork
			go(2'h3, 1'h0, 8'h01, 14'h0020, 14'h0300, 14'h0001);
			begin
				repeat (40) @(posedge aclk);
				chk("blocked", 0, rdcyc);
				core_ext_req <= 1'b0;
			end
		join
		axw(A_SYS, 32'h0018);
		go(2'h3, 1'h0, 8'h01, 14'h0020, 14'h0300, 14'h0001);
		chk("bsel", 0, bsel);
		chk("csel", 3, csel);
		axw(A_SYS, 32'h0);
		$display("waits done");
	endtask : t_waits
	task automatic t_boot();
		{irqs, rsts, holds} = '0;
		wq.delete();
		rst(1'b1);
		wdone();
		chk("boot words", 32, wq.size());
		chk("boot word", {pat(8'h0, 14'h0), pat(8'h0, 14'h1), pat(8'h0, 14'h2)}, wq[0]);
		chk("restart", 1, rsts);
		chk("held", 1, holds > 0);
		$display("boot done");
	endtask : t_boot
	task automatic results();
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : results

	// Main sequence
	initial
	begin
		rst(1'b0);
		t_regs();
		t_cross();
		t_formats();
		t_waits();
		t_boot();
		results();
	end
	// Watchdog
	initial
	begin
		repeat (40000) @(posedge aclk);
		errors++;
		$display("watchdog expired");
		results();
	end
endmodule : byte_memory_dma_tb
`default_nettype wire
